// [core/pmu_cfg.svh]
// port mirror unit: register offsets, field positions and reset values
// assumes a 32-bit classic Wishbone slave with byte addresses
`ifndef PMU_CFG_SVH
`define PMU_CFG_SVH
`define PMU_A_CTRL 8'h00
`define PMU_A_ADD 8'h04
`define PMU_A_DEL 8'h08
`define PMU_A_ING 8'h0c
`define PMU_A_EGR 8'h10
`define PMU_A_TRUNK 8'h14
`define PMU_A_STAT 8'h18
`define PMU_A_CNT 8'h1c
`define PMU_B_EN 0
`define PMU_F_MON 11:8
`define PMU_F_FIRST 3:0
`define PMU_F_LAST 11:8
`define PMU_F_MODE 17:16
`define PMU_F_MASK 15:0
`define PMU_F_REJ 1:0
`define PMU_B_REJMON 0
`define PMU_B_REJSRC 1
`define PMU_RST_MON 4'h0
`define PMU_ONE_CNT 32'h1
`endif

// [core/pmu_pkg.sv]
// port mirror unit: shared types
// assumes at most sixteen switch ports
package pmu_pkg;
  localparam int PMU_MAXP = 16;
  typedef enum logic [1:0] {
    PMU_OFF,
    PMU_ING,
    PMU_EGR,
    PMU_BOTH
  } pmu_mode_t;
  // forwarding decision arriving from the switch lookup
  typedef struct packed {
    logic [3:0] src;
    logic [15:0] mask;
  } pmu_dec_t;
  // decision after mirroring
  typedef struct packed {
    logic [3:0] src;
    logic [15:0] mask;
    logic mirrored;
  } pmu_fwd_t;
endpackage : pmu_pkg

// [core/pmu_top.sv]
// port mirror unit: edits forwarding decisions to add monitor copies
// assumes decisions arrive one per handshake in the switch core domain
//
// Decided for this implementation: the address map and the Wishbone register port.
`include "pmu_cfg.svh"
module pmu_top
  import pmu_pkg::*;
#(
  parameter int NPORTS = 12
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire pmu_dec_t IN_DEC,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output pmu_fwd_t OUT_FWD
);

  if (NPORTS < 2 || NPORTS > PMU_MAXP) begin : g_chk
    $error("NPORTS must be 2 to 16");
  end

  localparam logic [15:0] PM = 16'((32'h1 << NPORTS) - 32'h1);

  logic en_q, en_d;
  logic [3:0] mon_q, mon_d;
  logic [15:0] ing_q, ing_d;
  logic [15:0] egr_q, egr_d;
  logic [15:0] trk_q, trk_d;
  logic [1:0] rej_q, rej_d;
  logic [31:0] cnt_q, cnt_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic ov_q, ov_d;
  pmu_fwd_t of_q, of_d;

  logic bus_req;
  logic wr_fire;
  logic take;
  logic [7:0] wa;
  logic [31:0] bm;
  logic [15:0] rng;
  logic [15:0] mon_hot;
  logic [15:0] orig;
  logic mir;
  logic [3:0] first_p;
  logic [3:0] last_p;

  // bus decode; ack_q in the term makes every access take two cycles
  assign bus_req = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wr_fire = CE & bus_req & WB_WE_I;
  assign wa = {WB_ADR_I[7:2], 2'b00};
  assign bm = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
               {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign first_p = WB_DAT_I[`PMU_F_FIRST];
  assign last_p = WB_DAT_I[`PMU_F_LAST];
  assign mon_hot = 16'h1 << mon_q;

  // port range of an add or remove command; first above last is empty
  for (genvar i = 0; i < PMU_MAXP; i++) begin : g_rng
    assign rng[i] = (4'(i) >= first_p) && (4'(i) <= last_p) &&
                    (i < NPORTS);
  end

  // configuration next state
  always_comb begin
    logic [3:0] new_mon;
    logic [15:0] hot_d;
    logic [15:0] add;
    new_mon = WB_DAT_I[`PMU_F_MON];
    add = rng & ~mon_hot; // monitor is never taken as a source
    hot_d = 16'h0;
    en_d = en_q;
    mon_d = mon_q;
    ing_d = ing_q;
    egr_d = egr_q;
    trk_d = trk_q;
    rej_d = rej_q;
    if (wr_fire) begin
      case (wa)
        `PMU_A_CTRL: begin
          if (WB_SEL_I[0]) begin
            en_d = WB_DAT_I[`PMU_B_EN];
          end
          if (WB_SEL_I[1]) begin
            // trunk members and absent ports leave the monitor as is
            // five bits so that sixteen ports does not wrap to zero
            if ({1'b0, new_mon} >= 5'(NPORTS) || trk_q[new_mon]) begin
              rej_d[`PMU_B_REJMON] = 1'b1;
            end else begin
              mon_d = new_mon;
            end
          end
        end
        `PMU_A_ADD: begin
          if (|(rng & mon_hot)) begin
            rej_d[`PMU_B_REJSRC] = 1'b1;
          end
          // the mode replaces any earlier mode of those ports
          case (pmu_mode_t'(WB_DAT_I[`PMU_F_MODE]))
            PMU_ING: begin
              ing_d = ing_q | add;
              egr_d = egr_q & ~add;
            end
            PMU_EGR: begin
              ing_d = ing_q & ~add;
              egr_d = egr_q | add;
            end
            PMU_BOTH: begin
              ing_d = ing_q | add;
              egr_d = egr_q | add;
            end
            default: begin
              ing_d = ing_q & ~add;
              egr_d = egr_q & ~add;
            end
          endcase
        end
        `PMU_A_DEL: begin
          ing_d = ing_q & ~rng;
          egr_d = egr_q & ~rng;
        end
        `PMU_A_TRUNK: begin
          trk_d = ((trk_q & ~bm[15:0]) | (WB_DAT_I[15:0] & bm[15:0])) & PM;
        end
        `PMU_A_STAT: begin
          if (WB_SEL_I[0]) begin
            rej_d = rej_q & ~WB_DAT_I[`PMU_F_REJ]; // write one to clear
          end
        end
        default: begin
        end
      endcase
    end
    // a newly chosen monitor leaves the source sets
    hot_d = 16'h1 << mon_d;
    ing_d = ing_d & ~hot_d & PM;
    egr_d = egr_d & ~hot_d & PM;
  end

  // register read mux; unmapped addresses read zero and still ack
  always_comb begin
    ack_d = CE ? bus_req : ack_q;
    dat_d = dat_q;
    if (CE && bus_req && !WB_WE_I) begin
      dat_d = 32'h0;
      case (wa)
        `PMU_A_CTRL: begin
          dat_d[`PMU_B_EN] = en_q;
          dat_d[`PMU_F_MON] = mon_q;
        end
        `PMU_A_ING: dat_d[`PMU_F_MASK] = ing_q;
        `PMU_A_EGR: dat_d[`PMU_F_MASK] = egr_q;
        `PMU_A_TRUNK: dat_d[`PMU_F_MASK] = trk_q;
        `PMU_A_STAT: dat_d[`PMU_F_REJ] = rej_q;
        `PMU_A_CNT: dat_d = cnt_q;
        default: dat_d = 32'h0;
      endcase
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  // decision path: one register stage, stalls with OUT_READY
  assign IN_READY = ~ov_q | OUT_READY;
  assign take = CE & IN_VALID & IN_READY;
  assign orig = IN_DEC.mask & PM;
  assign mir = en_q &
               (ing_q[IN_DEC.src] |
                (|(egr_q & orig)));

  always_comb begin
    ov_d = ov_q;
    of_d = of_q;
    cnt_d = cnt_q;
    if (take) begin
      ov_d = 1'b1;
      of_d.src = IN_DEC.src;
      of_d.mirrored = mir;
      // regular traffic is kept off the monitor while enabled
      of_d.mask = en_q ? (orig & ~mon_hot) : orig;
      if (mir) begin
        of_d.mask = of_d.mask | mon_hot;
      end
    end else if (CE && OUT_READY) begin
      ov_d = 1'b0;
    end
    if (take && mir) begin
      cnt_d = cnt_q + `PMU_ONE_CNT;
    end
    // a copy counted in the clearing cycle is kept
    if (wr_fire && wa == `PMU_A_CNT) begin
      cnt_d = (take && mir) ? `PMU_ONE_CNT : 32'h0;
    end
  end

  assign OUT_VALID = ov_q;
  assign OUT_FWD = of_q;

  // all state; CE low freezes everything
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      en_q <= 1'b0;
      mon_q <= `PMU_RST_MON;
      ing_q <= 16'h0;
      egr_q <= 16'h0;
      trk_q <= 16'h0;
      rej_q <= 2'h0;
      cnt_q <= 32'h0;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      ov_q <= 1'b0;
      of_q <= '0;
    end else if (CE) begin
      en_q <= en_d;
      mon_q <= mon_d;
      ing_q <= ing_d;
      egr_q <= egr_d;
      trk_q <= trk_d;
      rej_q <= rej_d;
      cnt_q <= cnt_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      ov_q <= ov_d;
      of_q <= of_d;
    end
  end

  // checks on the decision path and on configuration
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  ing_copy_a: assert property (
    take && en_q && ing_q[IN_DEC.src]
    |=> OUT_FWD.mirrored && OUT_FWD.mask[$past(mon_q)])
    else $error("ingress copy missing");

  egr_copy_a: assert property (
    take && en_q && |(egr_q & IN_DEC.mask & PM)
    |=> OUT_FWD.mirrored && OUT_FWD.mask[$past(mon_q)])
    else $error("egress copy missing");

  both_copy_a: assert property (
    take && en_q && ing_q[IN_DEC.src] && egr_q[IN_DEC.src]
    |=> OUT_VALID && OUT_FWD.mirrored)
    else $error("both mode copy missing");

  off_none_a: assert property (
    take && !ing_q[IN_DEC.src] && !(|(egr_q & IN_DEC.mask))
    |=> !OUT_FWD.mirrored)
    else $error("copy of an unmirrored port");

  global_off_a: assert property (
    take && !en_q
    |=> !OUT_FWD.mirrored && OUT_FWD.mask == $past(orig))
    else $error("copy while disabled");

  mon_legal_a: assert property (
    {1'b0, mon_q} < 5'(NPORTS))
    else $error("monitor port out of range");

  trunk_rej_a: assert property (
    wr_fire && wa == `PMU_A_CTRL && WB_SEL_I[1] &&
    trk_q[WB_DAT_I[`PMU_F_MON]]
    |=> mon_q == $past(mon_q) && rej_q[`PMU_B_REJMON])
    else $error("trunk member taken as monitor");

  mon_nosrc_a: assert property (
    !ing_q[mon_q] && !egr_q[mon_q])
    else $error("monitor port is a source");

  mon_only_a: assert property (
    take && en_q && !mir |=> !OUT_FWD.mask[$past(mon_q)])
    else $error("regular traffic reached monitor");

  mon_drop_a: assert property (
    $changed(mon_q) |-> !ing_q[mon_q] && !egr_q[mon_q] &&
    (($past(ing_q) & ~mon_hot) == (ing_q & ~mon_hot)))
    else $error("new monitor still a source");

  add_port_a: assert property (
    wr_fire && wa == `PMU_A_ADD && first_p == last_p &&
    first_p != mon_q && {1'b0, first_p} < 5'(NPORTS) &&
    WB_DAT_I[`PMU_F_MODE] == 2'(PMU_BOTH)
    |=> ing_q[$past(first_p)] && egr_q[$past(first_p)])
    else $error("added port not a source");

  del_port_a: assert property (
    wr_fire && wa == `PMU_A_DEL
    |=> (ing_q & $past(rng)) == 16'h0 && (egr_q & $past(rng)) == 16'h0)
    else $error("removed port still a source");

  orig_keep_a: assert property (
    take |=> OUT_FWD.src == $past(IN_DEC.src) &&
    ((OUT_FWD.mask ^ $past(orig)) & ~$past(mon_hot)) == 16'h0)
    else $error("original forwarding altered");

endmodule : pmu_top

// [bench/pmu_sink.sv]
// analyzer-side sink model for the mirror unit's decision stream
// assumes pmu_top's valid/ready output handshake on the core clock
module pmu_sink
  import pmu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic valid,
  input wire pmu_fwd_t fwd,
  output logic ready,
  output pmu_fwd_t last,
  output int n_got
);
  timeunit 1ns;
  timeprecision 1ns;
  // ready toggles every cycle so a decision that finds ready low meets a one-cycle stall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ready <= 1'b0;
      n_got <= 0;
      last <= '0;
    end else begin
      ready <= ~ready;
      if (valid && ready) begin
        last <= fwd;
        n_got <= n_got + 1;
      end
    end
  end
endmodule : pmu_sink

// [bench/pmu_top_tb.sv]
// mirror unit bench: one task per scenario, wishbone and decisions
// assumes pmu_top with NPORTS 12 and the pmu_sink model
module pmu_top_tb
  import pmu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wen = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic in_valid = 1'b0;
  logic in_ready;
  logic out_valid;
  logic out_ready;
  pmu_dec_t in_dec = '0;
  pmu_fwd_t out_fwd;
  pmu_fwd_t got;
  int n_got;
  int n_fail = 0;
  int n_tests = 0;
  // 20 MHz core clock
  always #25 clk = ~clk;
  pmu_top #(.NPORTS(12)) i_pmu_top (
    .CLK(clk), .RST_N(rst_n), .CE(1'b1),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(wen), .WB_ADR_I(adr),
    .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .IN_VALID(in_valid), .IN_READY(in_ready), .IN_DEC(in_dec),
    .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_FWD(out_fwd)
  );
  pmu_sink i_pmu_sink (
    .clk(clk), .rst_n(rst_n), .valid(out_valid), .fwd(out_fwd),
    .ready(out_ready), .last(got), .n_got(n_got)
  );
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  // one classic cycle; entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 40);
    if (ack !== 1'b1) begin
      $display("MISMATCH wb_ack exp 1 got %b", ack);
      n_fail++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd
  // hand in one decision, wait for the sink to take the result
  task automatic dec(input logic [3:0] s, input logic [15:0] m,
                     input logic [15:0] em, input logic mir);
    int k;
    int n0;
    pmu_fwd_t e;
    k = 0;
    n0 = n_got;
    e = {s, em, mir};
    in_valid <= 1'b1;
    in_dec <= {s, m};
    do begin
      @(posedge clk);
      k++;
    end while (in_ready !== 1'b1 && k < 40);
    in_valid <= 1'b0;
    while (n_got == n0 && k < 80) begin
      @(posedge clk);
      k++;
    end
    if (n_got == n0) begin
      $display("MISMATCH sink_take exp 1 got 0");
      n_fail++;
    end
    chk("out_fwd", 32'(e), 32'(got));
  endtask : dec
  task automatic t_reset;
    rd(8'h00, 32'h0, "ctrl");
    rd(8'h0c, 32'h0, "ing");
    rd(8'h20, 32'h0, "unmapped");
    $display("test reset done");
  endtask : t_reset
  task automatic t_modes;
    wb(1'b1, 8'h00, 32'h0000_0900);
    wb(1'b1, 8'h04, 32'h0001_0101);
    wb(1'b1, 8'h04, 32'h0002_0202);
    wb(1'b1, 8'h04, 32'h0003_0303);
    wb(1'b1, 8'h04, 32'h0001_0404);
    wb(1'b1, 8'h04, 32'h0000_0404);
    wb(1'b1, 8'h00, 32'h0000_0901);
    rd(8'h0c, 32'h000a, "ing");
    rd(8'h10, 32'h000c, "egr");
    dec(4'h1, 16'h0020, 16'h0220, 1'b1);
    dec(4'h5, 16'h0004, 16'h0204, 1'b1);
    dec(4'h3, 16'h0001, 16'h0201, 1'b1);
    dec(4'h0, 16'h0008, 16'h0208, 1'b1);
    dec(4'h4, 16'h0010, 16'h0010, 1'b0);
    dec(4'h6, 16'h0201, 16'h0001, 1'b0);
    rd(8'h1c, 32'h4, "count");
    $display("test modes done");
  endtask : t_modes
  // trunk member refused as monitor, old monitor kept
  task automatic t_trunk;
    wb(1'b1, 8'h14, 32'h0080);
    wb(1'b1, 8'h00, 32'h0701);
    rd(8'h00, 32'h0901, "ctrl");
    rd(8'h18, 32'h1, "stat");
    rd(8'h14, 32'h0080, "trunk");
    wb(1'b1, 8'h18, 32'h3);
    $display("test trunk done");
  endtask : t_trunk
  task automatic t_move;
    wb(1'b1, 8'h00, 32'h0101);
    rd(8'h0c, 32'h0008, "ing");
    wb(1'b1, 8'h04, 32'h0003_0300);
    rd(8'h18, 32'h2, "stat");
    rd(8'h0c, 32'h000d, "ing");
    dec(4'h2, 16'h0002, 16'h0002, 1'b1);
    $display("test move done");
  endtask : t_move
  task automatic t_del;
    wb(1'b1, 8'h08, 32'h0000_0200);
    rd(8'h10, 32'h0008, "egr");
    dec(4'h0, 16'h0020, 16'h0020, 1'b0);
    $display("test remove done");
  endtask : t_del
  task automatic t_off;
    wb(1'b1, 8'h00, 32'h0100);
    dec(4'h3, 16'h0002, 16'h0002, 1'b0);
    wb(1'b1, 8'h1c, 32'h0);
    rd(8'h1c, 32'h0, "count");
    $display("test disable done");
  endtask : t_off
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  // main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_modes;
    t_trunk;
    t_move;
    t_del;
    t_off;
    stop_test;
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    stop_test;
  end
endmodule : pmu_top_tb
